/* File: logic/pdma_consts.svh */
// constants for the port data and logic-cell access block
`ifndef PDMA_CONSTS_SVH
`define PDMA_CONSTS_SVH

// ----------------------------------------------------------------
// port indices
// ----------------------------------------------------------------
`define PDMA_PORT_A 3'h0
`define PDMA_PORT_B 3'h1
`define PDMA_PORT_C 3'h2
`define PDMA_PORT_D 3'h3
`define PDMA_PORT_E 3'h4
`define PDMA_PORT_F 3'h5
`define PDMA_PORT_G 3'h6

// ----------------------------------------------------------------
// register codes, low nibble of the offset; high bits pick the port
// ----------------------------------------------------------------
`define PDMA_REG_PIN_INPUT 4'h0
`define PDMA_REG_OUTPUT_VALUE 4'h1
`define PDMA_REG_DIRECTION 4'h2
`define PDMA_REG_CONTROL 4'h3
`define PDMA_REG_DRIVE_SELECT 4'h4
`define PDMA_REG_CELL_VALUE 4'h5
`define PDMA_REG_CELL_MASK 4'h6
`define PDMA_REG_INPUT_CELL 4'h7
`define PDMA_REG_ENABLE_STATUS 4'h8

// ----------------------------------------------------------------
// which ports own which register, bit n = port n
// ----------------------------------------------------------------
`define PDMA_HAS_CONTROL 7'h70
`define PDMA_HAS_DRIVE 7'h5B
`define PDMA_HAS_CELLS 7'h03
`define PDMA_HAS_INPUT_CELLS 7'h07
`define PDMA_HAS_ENABLE_OUT 7'h27
`define PDMA_HAS_OE_TERM 7'h27
`define PDMA_PORT_D_MASK 8'h0F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PDMA_RESET_CONFIG 8'h00
`define PDMA_RESET_DATA 8'h00
`define PDMA_RESET_MASK 8'h00

`endif

/* File: logic/pdma_pkg.sv */
// types shared by the port data and logic-cell access block
package pdma_pkg;

	// one byte per port, index 0 = port A .. 6 = port G
	typedef logic [6:0][7:0] pdma_port_bytes_t;

	// register request from the on-chip host bus interface
	typedef struct packed {
		logic select;
		logic read;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pdma_bus_req_t;

	// static configuration fixed when the device is programmed
	typedef struct packed {
		logic [7:0] bank_a_route;
		logic [7:0] bank_b_route;
		logic [7:0] select_to_c;
		logic [7:0] select_to_f;
		logic input_cell_latch;
		logic chip_select_en;
		logic jtag_en;
		logic standby_supply_en;
		logic battery_on_en;
		logic data_port_en;
		logic reset_pattern_en;
		logic [15:0] reset_pattern;
	} pdma_cfg_t;

endpackage : pdma_pkg

/* File: logic/pdma_port_data.sv */
// port data path, logic-cell access and pin drivers for ports A to G
// Function
// - data register drives pins with direction or term
// - data register reads back written value
// - output cells mapped; read returns cell outputs
// - cell write loads only unmasked bits
// - mask bit one blocks load; resets zero
// - mask exists for A and B, read-write
// - input cells capture pins, feed array, readable
// - enable status one drives, zero tri-state
// - enable status for A,B,C,F, read-only
// - cell banks to A/B, selects to C/F
// - every port A pin may be open drain
// - port D four pins, direct array inputs
// - port D strobe, clock, select, high write
// - chip select high blocks register access
// - port E jtag, open drain, address, battery
// - port F low data byte, address, inputs
// - port G high data byte, address, open drain
// - F/G drive pattern during host reset
// - direction one output, zero input; term forces
// - control zero data mode, one address out
// - drive bit one gives open drain
// - configuration registers reset to zero
`timescale 1ns/1ns
`include "pdma_consts.svh"

module pdma_port_data import pdma_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire pdma_bus_req_t bus_req,
	output logic [7:0] bus_rdata,
	output logic bus_rvalid,
	input wire pdma_port_bytes_t pin_in,
	output pdma_port_bytes_t pin_out,
	output pdma_port_bytes_t pin_oe,
	input wire pdma_port_bytes_t logic_oe_term,
	input wire logic [7:0] bank_a_next,
	input wire logic [7:0] bank_b_next,
	input wire logic [7:0] external_select_outputs,
	input wire pdma_cfg_t cfg,
	input wire logic [15:0] latched_address,
	input wire logic [15:0] data_port_out,
	input wire logic data_port_drive,
	input wire logic host_reset_active,
	input wire logic bus_cycle_active,
	input wire logic battery_on_indicator,
	output logic [7:0] bank_a_output_cells,
	output logic [7:0] bank_b_output_cells,
	output logic [2:0][7:0] input_logic_cell,
	output pdma_port_bytes_t pin_level,
	output logic address_strobe_in,
	output logic logic_clock_tick,
	output logic chip_select_in,
	output logic high_byte_write_enable
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	pdma_port_bytes_t pin_meta;
	pdma_port_bytes_t pin_sync;
	logic clock_prev;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// the logic array sees the pin levels; port D keeps only its low four pins
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_level <= '0;
		end else begin
			pin_level <= pin_sync;
			pin_level[`PDMA_PORT_D] <= pin_sync[`PDMA_PORT_D] & `PDMA_PORT_D_MASK;
		end
	end

	// dedicated port D inputs
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			address_strobe_in <= 1'b0;
			chip_select_in <= 1'b0;
			high_byte_write_enable <= 1'b0;
			clock_prev <= 1'b0;
			logic_clock_tick <= 1'b0;
		end else begin
			address_strobe_in <= pin_sync[`PDMA_PORT_D][0];
			chip_select_in <= pin_sync[`PDMA_PORT_D][2];
			high_byte_write_enable <= pin_sync[`PDMA_PORT_D][3];
			clock_prev <= pin_sync[`PDMA_PORT_D][1];
			logic_clock_tick <= pin_sync[`PDMA_PORT_D][1] & ~clock_prev;
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic [2:0] sel_port;
	logic [3:0] sel_reg;
	logic port_valid;
	logic access_ok;
	logic do_write;
	logic do_read;

	assign sel_port = bus_req.addr[6:4];
	assign sel_reg = bus_req.addr[3:0];
	assign port_valid = ~bus_req.addr[7] && (sel_port != 3'h7);
	// a high chip select shuts out register access, pins keep running
	assign access_ok = bus_req.select && !(cfg.chip_select_en && chip_select_in);
	assign do_write = access_ok && bus_req.write && port_valid;
	assign do_read = access_ok && bus_req.read && port_valid;

	// ----------------------------------------------------------------
	// port configuration and data registers
	// ----------------------------------------------------------------
	pdma_port_bytes_t out_value;
	pdma_port_bytes_t direction;
	pdma_port_bytes_t control;
	pdma_port_bytes_t drive_sel;
	logic [1:0][7:0] cell_mask;

	function automatic logic owns(input logic [6:0] map, input logic [2:0] port);
		owns = map[port];
	endfunction : owns

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			out_value <= {7{`PDMA_RESET_DATA}};
			direction <= {7{`PDMA_RESET_CONFIG}};
			control <= {7{`PDMA_RESET_CONFIG}};
			drive_sel <= {7{`PDMA_RESET_CONFIG}};
		end else if (do_write) begin
			case (sel_reg)
				`PDMA_REG_OUTPUT_VALUE: begin
					out_value[sel_port] <= bus_req.wdata;
				end
				`PDMA_REG_DIRECTION: begin
					if (sel_port == `PDMA_PORT_D) begin
						direction[sel_port] <= bus_req.wdata & `PDMA_PORT_D_MASK;
					end else begin
						direction[sel_port] <= bus_req.wdata;
					end
				end
				`PDMA_REG_CONTROL: begin
					if (owns(`PDMA_HAS_CONTROL, sel_port)) begin
						control[sel_port] <= bus_req.wdata;
					end
				end
				`PDMA_REG_DRIVE_SELECT: begin
					if (owns(`PDMA_HAS_DRIVE, sel_port)) begin
						drive_sel[sel_port] <= bus_req.wdata;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// mask registers guard the cell banks of ports A and B only
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cell_mask <= {2{`PDMA_RESET_MASK}};
		end else if (do_write && sel_reg == `PDMA_REG_CELL_MASK
			&& owns(`PDMA_HAS_CELLS, sel_port)) begin
			cell_mask[sel_port[0]] <= bus_req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// output logic cells
	// ----------------------------------------------------------------
	logic cell_write;
	logic [7:0] load_a;
	logic [7:0] load_b;

	assign cell_write = do_write && sel_reg == `PDMA_REG_CELL_VALUE
		&& owns(`PDMA_HAS_CELLS, sel_port);
	// a host load only touches unmasked bits; it beats the array clock there
	assign load_a = (cell_write && sel_port == `PDMA_PORT_A) ? ~cell_mask[0] : 8'h00;
	assign load_b = (cell_write && sel_port == `PDMA_PORT_B) ? ~cell_mask[1] : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bank_a_output_cells <= `PDMA_RESET_DATA;
			bank_b_output_cells <= `PDMA_RESET_DATA;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (load_a[i]) begin
					bank_a_output_cells[i] <= bus_req.wdata[i];
				end else if (logic_clock_tick) begin
					bank_a_output_cells[i] <= bank_a_next[i];
				end
				if (load_b[i]) begin
					bank_b_output_cells[i] <= bus_req.wdata[i];
				end else if (logic_clock_tick) begin
					bank_b_output_cells[i] <= bank_b_next[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// input logic cells of ports A, B and C
	// ----------------------------------------------------------------
	logic in_capture;

	// latch mode follows the address strobe, register mode the array clock
	assign in_capture = cfg.input_cell_latch ? address_strobe_in : logic_clock_tick;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			input_logic_cell <= '0;
		end else if (in_capture) begin
			for (int p = 0; p < 3; p++) begin
				input_logic_cell[p] <= pin_sync[p];
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drive selection
	// ----------------------------------------------------------------
	pdma_port_bytes_t drive_value;
	pdma_port_bytes_t drive_enable;
	pdma_port_bytes_t next_pin_out;
	pdma_port_bytes_t next_pin_oe;
	pdma_port_bytes_t enable_status;
	logic reset_drive;

	// pattern only while the host sits in reset with no cycle running
	assign reset_drive = cfg.reset_pattern_en && host_reset_active && !bus_cycle_active;

	always_comb begin
		for (int p = 0; p < 7; p++) begin
			drive_value[p] = out_value[p];
			drive_enable[p] = direction[p];
			if (owns(`PDMA_HAS_OE_TERM, 3'(p))) begin
				drive_enable[p] = direction[p] | logic_oe_term[p];
			end
		end
		drive_value[`PDMA_PORT_A] = (cfg.bank_a_route & bank_a_output_cells)
			| (~cfg.bank_a_route & out_value[`PDMA_PORT_A]);
		drive_value[`PDMA_PORT_B] = (cfg.bank_b_route & bank_b_output_cells)
			| (~cfg.bank_b_route & out_value[`PDMA_PORT_B]);
		drive_value[`PDMA_PORT_C] = (cfg.select_to_c & external_select_outputs)
			| (~cfg.select_to_c & out_value[`PDMA_PORT_C]);
		drive_value[`PDMA_PORT_F] = (cfg.select_to_f & external_select_outputs)
			| (~cfg.select_to_f & out_value[`PDMA_PORT_F]);
		drive_value[`PDMA_PORT_D] = out_value[`PDMA_PORT_D] & `PDMA_PORT_D_MASK;
		drive_enable[`PDMA_PORT_D] = direction[`PDMA_PORT_D] & `PDMA_PORT_D_MASK;
		// address out mode per pin on E, F and G
		drive_value[`PDMA_PORT_E] = (control[`PDMA_PORT_E] & latched_address[7:0])
			| (~control[`PDMA_PORT_E] & drive_value[`PDMA_PORT_E]);
		drive_enable[`PDMA_PORT_E] = drive_enable[`PDMA_PORT_E] | control[`PDMA_PORT_E];
		drive_value[`PDMA_PORT_F] = (control[`PDMA_PORT_F] & latched_address[7:0])
			| (~control[`PDMA_PORT_F] & drive_value[`PDMA_PORT_F]);
		drive_enable[`PDMA_PORT_F] = drive_enable[`PDMA_PORT_F] | control[`PDMA_PORT_F];
		drive_value[`PDMA_PORT_G] = (control[`PDMA_PORT_G] & latched_address[15:8])
			| (~control[`PDMA_PORT_G] & drive_value[`PDMA_PORT_G]);
		drive_enable[`PDMA_PORT_G] = drive_enable[`PDMA_PORT_G] | control[`PDMA_PORT_G];
		// battery pins: standby supply is input only, indicator is driven
		if (cfg.standby_supply_en) begin
			drive_enable[`PDMA_PORT_E][6] = 1'b0;
		end
		if (cfg.battery_on_en) begin
			drive_value[`PDMA_PORT_E][7] = battery_on_indicator;
			drive_enable[`PDMA_PORT_E][7] = 1'b1;
		end
		// the programming port owns the low six pins of E while enabled
		if (cfg.jtag_en) begin
			drive_enable[`PDMA_PORT_E][5:0] = 6'h00;
		end
		// data port: F carries the low byte, G the high byte
		if (cfg.data_port_en) begin
			drive_value[`PDMA_PORT_F] = data_port_out[7:0];
			drive_value[`PDMA_PORT_G] = data_port_out[15:8];
			drive_enable[`PDMA_PORT_F] = {8{data_port_drive}};
			drive_enable[`PDMA_PORT_G] = {8{data_port_drive}};
		end
		if (reset_drive) begin
			drive_value[`PDMA_PORT_F] = cfg.reset_pattern[7:0];
			drive_value[`PDMA_PORT_G] = cfg.reset_pattern[15:8];
			drive_enable[`PDMA_PORT_F] = 8'hFF;
			drive_enable[`PDMA_PORT_G] = 8'hFF;
		end
		// open drain pins only pull low; a one releases the wire
		for (int p = 0; p < 7; p++) begin
			enable_status[p] = drive_enable[p];
			next_pin_out[p] = drive_value[p];
			next_pin_oe[p] = drive_enable[p];
			if (owns(`PDMA_HAS_DRIVE, 3'(p))) begin
				next_pin_out[p] = drive_value[p] & ~drive_sel[p];
				next_pin_oe[p] = drive_enable[p] & ~(drive_sel[p] & drive_value[p]);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
		end
	end

	// ----------------------------------------------------------------
	// register read-back
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		case (sel_reg)
			`PDMA_REG_PIN_INPUT: begin
				next_rdata = pin_sync[sel_port];
			end
			`PDMA_REG_OUTPUT_VALUE: begin
				next_rdata = out_value[sel_port];
			end
			`PDMA_REG_DIRECTION: begin
				next_rdata = direction[sel_port];
			end
			`PDMA_REG_CONTROL: begin
				next_rdata = control[sel_port];
			end
			`PDMA_REG_DRIVE_SELECT: begin
				next_rdata = drive_sel[sel_port];
			end
			`PDMA_REG_CELL_VALUE: begin
				if (sel_port == `PDMA_PORT_A) begin
					next_rdata = bank_a_output_cells;
				end else if (sel_port == `PDMA_PORT_B) begin
					next_rdata = bank_b_output_cells;
				end
			end
			`PDMA_REG_CELL_MASK: begin
				if (owns(`PDMA_HAS_CELLS, sel_port)) begin
					next_rdata = cell_mask[sel_port[0]];
				end
			end
			`PDMA_REG_INPUT_CELL: begin
				if (owns(`PDMA_HAS_INPUT_CELLS, sel_port)) begin
					next_rdata = input_logic_cell[sel_port[1:0]];
				end
			end
			`PDMA_REG_ENABLE_STATUS: begin
				if (owns(`PDMA_HAS_ENABLE_OUT, sel_port)) begin
					next_rdata = enable_status[sel_port];
				end
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bus_rdata <= 8'h00;
			bus_rvalid <= 1'b0;
		end else begin
			bus_rvalid <= do_read;
			if (do_read) begin
				bus_rdata <= next_rdata;
			end
		end
	end

endmodule : pdma_port_data

/* File: bench/pdma_checker.sv */
// assertions on the port data block bus, pin sync and cell ports
`timescale 1ns/1ns
module pdma_checker import pdma_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire pdma_bus_req_t bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rvalid,
	input wire pdma_port_bytes_t pin_in,
	input wire pdma_port_bytes_t pin_level,
	input wire logic logic_clock_tick,
	input wire logic chip_select_in,
	input wire logic [7:0] bank_a_output_cells,
	input wire pdma_cfg_t cfg
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic [1:0] warm;
	logic blocked;
	logic taken_rd;
	logic wr_cell_a;
	assign blocked = cfg.chip_select_en && chip_select_in;
	assign taken_rd = bus_req.select && bus_req.read && !bus_req.addr[7]
		&& bus_req.addr[6:4] != 3'h7 && !blocked;
	assign wr_cell_a = bus_req.select && bus_req.write && bus_req.addr == 8'h05 && !blocked;
	// pin checks wait until the synchroniser holds post-reset samples only
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			warm <= 2'h0;
		end else if (warm != 2'h3) begin
			warm <= warm + 2'h1;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	read_answer_a: assert property (taken_rd |=> bus_rvalid) else $error("read not answered");
	no_spurious_a: assert property (bus_rvalid |-> $past(taken_rd)) else $error("stray rvalid");
	select_refuse_a: assert property (
		bus_req.select && bus_req.read && blocked |=> !bus_rvalid)
		else $error("read taken while deselected");
	high_addr_a: assert property (
		bus_req.select && bus_req.read && bus_req.addr[7] |=> !bus_rvalid)
		else $error("read outside block answered");
	rdata_hold_a: assert property (!bus_rvalid |-> $stable(bus_rdata)) else $error("rdata moved");
	tick_pulse_a: assert property (logic_clock_tick |=> !logic_clock_tick)
		else $error("tick longer than one cycle");
	cell_cause_a: assert property (
		$changed(bank_a_output_cells) |-> $past(logic_clock_tick) || $past(wr_cell_a))
		else $error("cells changed without cause");
	pin_sync_a: assert property (
		warm == 2'h3 |-> pin_level == ($past(pin_in, 3) & 56'hFFFFFF0FFFFFFF))
		else $error("pin level wrong");
	select_sync_a: assert property (
		warm == 2'h3 |-> chip_select_in == $past(pin_in[3][2], 3))
		else $error("chip select level wrong");
endmodule : pdma_checker

bind pdma_port_data pdma_checker u_chk (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pin_in(pin_in), .pin_level(pin_level),
	.logic_clock_tick(logic_clock_tick), .chip_select_in(chip_select_in),
	.bank_a_output_cells(bank_a_output_cells), .cfg(cfg));

/* File: bench/pdma_host_model.sv */
// host model issuing register cycles on the on-chip request bus
`timescale 1ns/1ns
module pdma_host_model import pdma_pkg::*; (
	input wire logic clk_sys,
	input wire logic [7:0] bus_rdata,
	input wire logic bus_rvalid,
	output pdma_bus_req_t bus_req
);
	// ----------------------------------------------------------------
	// cycles, driven on the falling edge
	// ----------------------------------------------------------------
	initial bus_req = '0;
	// idle lines show inverted data so a stale value is never mistaken for a hold
	task release_bus();
		bus_req.select = 1'b0;
		bus_req.read = 1'b0;
		bus_req.write = 1'b0;
		bus_req.addr = ~bus_req.addr;
		bus_req.wdata = ~bus_req.wdata;
	endtask : release_bus
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		bus_req = '{select: 1'b1, read: 1'b0, write: 1'b1, addr: a, wdata: d};
		@(negedge clk_sys);
		release_bus();
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge clk_sys);
		bus_req = '{select: 1'b1, read: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		// the answer stands for one cycle only, so take it before letting go
		ok = bus_rvalid;
		d = bus_rdata;
		release_bus();
	endtask : rd
endmodule : pdma_host_model

/* File: bench/tb_port_data_and_macrocell_access.sv */
// self-checking bench for the port data and logic-cell access block
`timescale 1ns/1ns
module tb_port_data_and_macrocell_access import pdma_pkg::*;;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	pdma_bus_req_t bus_req;
	logic [7:0] bus_rdata;
	logic bus_rvalid;
	pdma_port_bytes_t pin_in = '0, pin_out, pin_oe, logic_oe_term = '0, pin_level;
	logic [7:0] bank_a_next = 8'h00, bank_b_next = 8'h00, bank_a_cells, bank_b_cells;
	pdma_cfg_t cfg = '0;
	logic [15:0] latched_address = 16'h0000;
	logic host_reset_active = 1'b0;
	logic [7:0] ext_sel = 8'h00;
	logic [15:0] data_out = 16'h0000;
	logic data_drive = 1'b0, bus_cycle = 1'b0, battery_on = 1'b0;
	logic tick, strobe, csel, hwe;
	logic [2:0][7:0] in_cells;
	int num_errors = 0, samples_checked = 0;
	pdma_port_data dut (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .logic_oe_term(logic_oe_term), .bank_a_next(bank_a_next),
		.bank_b_next(bank_b_next), .external_select_outputs(ext_sel), .cfg(cfg),
		.latched_address(latched_address), .data_port_out(data_out), .data_port_drive(data_drive),
		.host_reset_active(host_reset_active), .bus_cycle_active(bus_cycle),
		.battery_on_indicator(battery_on), .bank_a_output_cells(bank_a_cells),
		.bank_b_output_cells(bank_b_cells), .input_logic_cell(in_cells), .pin_level(pin_level),
		.address_strobe_in(strobe), .logic_clock_tick(tick), .chip_select_in(csel),
		.high_byte_write_enable(hwe));
	pdma_host_model u_host (.clk_sys(clk_sys), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
		.bus_req(bus_req));
	// ----------------------------------------------------------------
	// compare and report
	// ----------------------------------------------------------------
	initial forever #2 clk_sys = ~clk_sys;
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
		end
	endtask : chk8
	task chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
		end
	endtask : chk1
	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_host.rd(a, d, ok);
		chk1(ok, 1'b1);
		chk8(d, exp);
	endtask : rdchk
	task wait_n(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : wait_n
	task close_out();
		$display("errors %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset_values();
		logic [7:0] d;
		logic ok;
		rdchk(8'h02, 8'h00);
		rdchk(8'h43, 8'h00);
		rdchk(8'h04, 8'h00);
		rdchk(8'h06, 8'h00);
		rdchk(8'h28, 8'h00);
		rdchk(8'h2F, 8'h00);
		u_host.rd(8'h80, d, ok);
		chk1(ok, 1'b0);
	endtask : t_reset_values
	task t_data_out();
		u_host.wr(8'h21, 8'hA5);
		u_host.wr(8'h22, 8'h0F);
		u_host.wr(8'h32, 8'hFF);
		rdchk(8'h21, 8'hA5);
		chk8(pin_out[2], 8'hA5);
		chk8(pin_oe[2], 8'h0F);
		chk8(pin_oe[3], 8'h0F);
		logic_oe_term[2] = 8'hF0;
		pin_in[2] = 8'h3C;
		wait_n(4);
		chk8(pin_oe[2], 8'hFF);
		rdchk(8'h28, 8'hFF);
		rdchk(8'h20, 8'h3C);
		rdchk(8'h21, 8'hA5);
		u_host.wr(8'h28, 8'h00);
		rdchk(8'h28, 8'hFF);
	endtask : t_data_out
	task t_open_drain();
		u_host.wr(8'h04, 8'h01);
		u_host.wr(8'h02, 8'h01);
		u_host.wr(8'h01, 8'h01);
		wait_n(3);
		chk8(pin_oe[0], 8'h00);
		u_host.wr(8'h01, 8'h00);
		wait_n(3);
		chk8(pin_oe[0], 8'h01);
		chk8(pin_out[0], 8'h00);
		rdchk(8'h08, 8'h01);
	endtask : t_open_drain
	task t_cells();
		u_host.wr(8'h06, 8'h0F);
		rdchk(8'h06, 8'h0F);
		u_host.wr(8'h05, 8'hFF);
		rdchk(8'h05, 8'hF0);
		chk8(bank_a_cells, 8'hF0);
		u_host.wr(8'h16, 8'hFF);
		u_host.wr(8'h15, 8'hAA);
		rdchk(8'h15, 8'h00);
		cfg.bank_a_route = 8'hFF;
		wait_n(3);
		chk8(pin_out[0], 8'hF0);
		// array clock loads every cell, mask only guards host loads
		bank_a_next = 8'h5A;
		bank_b_next = 8'hC3;
		pin_in[0] = 8'h3C;
		wait_n(4);
		pin_in[3] = 8'h02;
		wait_n(6);
		pin_in[3] = 8'h00;
		wait_n(4);
		chk8(bank_a_cells, 8'h5A);
		chk8(bank_b_cells, 8'hC3);
		rdchk(8'h07, 8'h3C);
		chk8(in_cells[0], 8'h3C);
	endtask : t_cells
	task t_address_out();
		latched_address = 16'hB64D;
		u_host.wr(8'h43, 8'hFF);
		u_host.wr(8'h63, 8'hFF);
		wait_n(3);
		chk8(pin_out[4], 8'h4D);
		chk8(pin_out[6], 8'hB6);
	endtask : t_address_out
	task t_chip_select();
		logic [7:0] d;
		logic ok;
		cfg.chip_select_en = 1'b1;
		pin_in[3] = 8'h0D;
		wait_n(5);
		chk1(csel, 1'b1);
		chk1(strobe, 1'b1);
		chk1(hwe, 1'b1);
		u_host.rd(8'h21, d, ok);
		chk1(ok, 1'b0);
		u_host.wr(8'h21, 8'h00);
		pin_in[3] = 8'h00;
		wait_n(5);
		rdchk(8'h21, 8'hA5);
	endtask : t_chip_select
	task t_reset_pattern();
		cfg.reset_pattern_en = 1'b1;
		cfg.reset_pattern = 16'h9E71;
		host_reset_active = 1'b1;
		wait_n(4);
		chk8(pin_out[5], 8'h71);
		chk8(pin_out[6], 8'h9E);
		host_reset_active = 1'b0;
	endtask : t_reset_pattern
	task t_special_modes();
		cfg.select_to_c = 8'hF0;
		ext_sel = 8'h96;
		cfg.bank_b_route = 8'hFF;
		wait_n(3);
		chk8(pin_out[2], 8'h95);
		chk8(pin_out[1], 8'hC3);
		cfg.data_port_en = 1'b1;
		data_out = 16'h5AC3;
		data_drive = 1'b1;
		wait_n(3);
		chk8(pin_out[5], 8'hC3);
		chk8(pin_out[6], 8'h5A);
		chk8(pin_oe[6], 8'hFF);
		// a running bus cycle keeps the reset pattern off the data lines
		host_reset_active = 1'b1;
		bus_cycle = 1'b1;
		wait_n(3);
		chk8(pin_out[5], 8'hC3);
		bus_cycle = 1'b0;
		wait_n(3);
		chk8(pin_out[5], 8'h71);
		host_reset_active = 1'b0;
		cfg.jtag_en = 1'b1;
		cfg.standby_supply_en = 1'b1;
		cfg.battery_on_en = 1'b1;
		battery_on = 1'b1;
		wait_n(3);
		chk8(pin_oe[4], 8'h80);
		chk8(pin_out[4], 8'hCD);
		cfg.input_cell_latch = 1'b1;
		pin_in[1] = 8'h77;
		wait_n(3);
		pin_in[3] = 8'h01;
		wait_n(5);
		pin_in[3] = 8'h00;
		wait_n(3);
		pin_in[1] = 8'h11;
		wait_n(4);
		chk8(in_cells[1], 8'h77);
	endtask : t_special_modes
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		t_reset_values();
		t_data_out();
		t_open_drain();
		t_cells();
		t_address_out();
		t_chip_select();
		t_reset_pattern();
		t_special_modes();
		close_out();
	end
	// the whole run is about 150 cycles; this allows over thirty times that
	initial begin
		#20000;
		num_errors++;
		close_out();
	end
endmodule : tb_port_data_and_macrocell_access
